// >>> src/epo_cfg.svh
`ifndef EPO_CFG_SVH
`define EPO_CFG_SVH

`define CLK_HZ 64'd100000000
`define RATE_FS 64'd65535
`define BASE_MHZ_0 64'd1720
`define BASE_MHZ_1 64'd3440
`define BASE_MHZ_2 64'd6860
`define BASE_MHZ_3 64'd13500
`define MULT_FAST 12'd2048
`define MULT_SCALED 12'd64
`define MULT_PLAIN 12'd128
`define CREEP_PPM 64'd45
`define PEAK_MIN_PCT 64'd9
`define PULSE_MAX_MS 64'd90
`define ZC_TIMEOUT_MS 64'd50
`define PULSE_MAX_CYC (`PULSE_MAX_MS * `CLK_HZ / 64'd1000)
`define ZC_TIMEOUT_CYC (`ZC_TIMEOUT_MS * `CLK_HZ / 64'd1000)

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_STATE 8'h0c
`define REG_COUNT 8'h10
`define CTRL_RST 1'b1
`define MASK_RST 4'h0
`define EV_CF 0
`define EV_REV 1
`define EV_FAULT_IN 2
`define EV_FAULT_OUT 3
`endif

// >>> src/epo_pkg.sv
package epo_pkg;
    typedef enum logic {
        MODE_NORMAL = 1'b0,
        MODE_MISSING = 1'b1
    } bill_mode_t;
    typedef logic [31:0] cycles_t;
endpackage : epo_pkg

// >>> src/pulse_if.sv
`timescale 1ns/1ps
interface pulse_if;
    logic fire;
    epo_pkg::cycles_t width_max;
    logic pulse;
    modport src (output fire, output width_max, input pulse);
    modport shaper (input fire, input width_max, output pulse);
endinterface : pulse_if

// >>> src/pulse_shaper.sv
`timescale 1ns/1ps
module pulse_shaper
    import epo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    pulse_if.shaper pif
);
    cycles_t period_ff;
    cycles_t remain_ff;
    logic out_ff;
    cycles_t nxt_width;
    cycles_t hi_cnt_ff;

    always_comb
    begin
        nxt_width = period_ff >> 1;
        if (nxt_width > pif.width_max)
        begin
            nxt_width = pif.width_max;
        end
        if (nxt_width == 32'h0)
        begin
            nxt_width = 32'h1;
        end
    end

    // period restarts at reset as saturated so the first pulse gets full width
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            period_ff <= 32'hffff_ffff;
        else if (pif.fire)
            period_ff <= 32'h1;
        else if (period_ff != 32'hffff_ffff)
            period_ff <= period_ff + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            remain_ff <= 32'h0;
            out_ff <= 1'b0;
        end
        else if (pif.fire)
        begin
            remain_ff <= nxt_width - 32'h1;
            out_ff <= 1'b1;
        end
        else if (remain_ff != 32'h0)
            remain_ff <= remain_ff - 32'h1;
        else
            out_ff <= 1'b0;
    end

    assign pif.pulse = out_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || pif.fire)
            hi_cnt_ff <= 32'h0;
        else if (out_ff)
            hi_cnt_ff <= hi_cnt_ff + 32'h1;
    end

    property p_fire_starts;
        @(posedge clk_i) disable iff (rst_i) pif.fire |=> out_ff;
    endproperty
    a_fire_starts: assert property (p_fire_starts) else $error("pulse did not start after fire");

    property p_width_cap;
        @(posedge clk_i) disable iff (rst_i) hi_cnt_ff <= pif.width_max;
    endproperty
    a_width_cap: assert property (p_width_cap) else $error("pulse longer than maximum width");

    property p_half_period;
        @(posedge clk_i) disable iff (rst_i)
            pif.fire && period_ff == 32'h4 && pif.width_max > 32'h2 |=> out_ff ##1 out_ff ##1 !out_ff;
    endproperty
    a_half_period: assert property (p_half_period) else $error("short period pulse not half width");
endmodule : pulse_shaper

// >>> src/energy_pulse_output_logic.sv
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "epo_cfg.svh"
module energy_pulse_output_logic
    import epo_pkg::*;
#(
    parameter cycles_t PULSE_MAX_CYC = 32'(`PULSE_MAX_CYC),
    parameter cycles_t ZC_TIMEOUT_CYC = 32'(`ZC_TIMEOUT_CYC)
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic freq_select_lo_i,
    input wire logic freq_select_hi_i,
    input wire logic cal_scale_select_i,
    input wire logic signed [16:0] power_rate_i,
    input wire logic [15:0] amp_rate_i,
    input wire logic [15:0] v_peak_i,
    input wire logic zero_cross_i,
    output logic calibration_pulse_out_o,
    output logic counter_drive_a_o,
    output logic counter_drive_b_o,
    output logic reverse_power_flag_o,
    output logic fault_o,
    output logic irq_o
);
    logic [1:0] sel;
    logic fast_mode;
    logic [11:0] mult;
    logic [39:0] threshold;
    logic [16:0] power_mag;
    logic [16:0] rate_sel;
    logic creep_block;
    logic [39:0] acc_ff;
    logic [39:0] nxt_acc;
    logic cf_fire_ff;
    logic cd_fire_ff;
    logic [11:0] cd_cnt_ff;
    logic rev_ff;
    logic peak_low;
    logic zc_lost;
    cycles_t zc_cnt_ff;
    bill_mode_t mode_ff;
    bill_mode_t nxt_mode;
    logic enable_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] ev_set;
    logic [31:0] count_ff;
    logic ack_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;
    logic bus_req;
    logic bus_wr;
    logic [1:0] fire_vec;
    logic [1:0] pulse_vec;

    assign sel = {freq_select_hi_i, freq_select_lo_i};
    assign fast_mode = !cal_scale_select_i && (sel == 2'b11);

    // accumulator threshold for one calibration pulse at full-scale rate
    function automatic logic [39:0] cf_threshold(input logic [1:0] s, input logic [11:0] m);
        logic [63:0] base;
        base = `BASE_MHZ_0;
        unique case (s)
            2'b00: base = `BASE_MHZ_0;
            2'b01: base = `BASE_MHZ_1;
            2'b10: base = `BASE_MHZ_2;
            2'b11: base = `BASE_MHZ_3;
        endcase
        return 40'(`RATE_FS * `CLK_HZ * 64'd1000 / (base * {52'h0, m}));
    endfunction : cf_threshold

    always_comb
    begin
        if (fast_mode)
            mult = `MULT_FAST;
        else if (cal_scale_select_i)
            mult = `MULT_SCALED;
        else
            mult = `MULT_PLAIN;
    end

    assign threshold = cf_threshold(sel, mult);

    // sign of the product marks a phase shift beyond a quarter cycle
    assign power_mag = power_rate_i[16] ? 17'(-power_rate_i) : 17'(power_rate_i);
    assign rate_sel = (mode_ff == MODE_MISSING) ? {1'b0, amp_rate_i} : power_mag;

    // compared as products so no rate is lost to integer division
    assign creep_block = !fast_mode
        && ({47'h0, rate_sel} * 64'd1000000 < `RATE_FS * `CREEP_PPM);

    always_comb
    begin
        nxt_acc = acc_ff + {23'h0, rate_sel};
        if (nxt_acc >= threshold)
            nxt_acc = nxt_acc - threshold;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_ff <= 40'h0;
            cf_fire_ff <= 1'b0;
        end
        else if (enable_ff && !creep_block)
        begin
            acc_ff <= nxt_acc;
            cf_fire_ff <= (acc_ff + {23'h0, rate_sel}) >= threshold;
        end
        else
            cf_fire_ff <= 1'b0;
    end

    // counter drive is the calibration train divided down by the scaling
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cd_cnt_ff <= 12'h0;
            cd_fire_ff <= 1'b0;
        end
        else if (cf_fire_ff)
        begin
            cd_fire_ff <= cd_cnt_ff >= mult - 12'h1;
            cd_cnt_ff <= (cd_cnt_ff >= mult - 12'h1) ? 12'h0 : cd_cnt_ff + 12'h1;
        end
        else
            cd_fire_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rev_ff <= 1'b0;
        else if (cf_fire_ff)
            rev_ff <= power_rate_i[16];
    end

    assign fire_vec = {cd_fire_ff, cf_fire_ff};

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_shape
            pulse_if pif ();
            assign pif.fire = fire_vec[g];
            assign pif.width_max = PULSE_MAX_CYC;
            assign pulse_vec[g] = pif.pulse;
            pulse_shaper u_shaper (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pif(pif.shaper)
            );
        end
    endgenerate

    assign calibration_pulse_out_o = pulse_vec[0];
    assign counter_drive_a_o = pulse_vec[1];
    assign counter_drive_b_o = pulse_vec[1];
    assign reverse_power_flag_o = rev_ff;

    assign peak_low = {48'h0, v_peak_i} * 64'd100 < `RATE_FS * `PEAK_MIN_PCT;
    assign zc_lost = (zc_cnt_ff >= ZC_TIMEOUT_CYC);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || zero_cross_i)
            zc_cnt_ff <= 32'h0;
        else if (!zc_lost)
            zc_cnt_ff <= zc_cnt_ff + 32'h1;
    end

    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            MODE_NORMAL:
                if (peak_low || zc_lost)
                    nxt_mode = MODE_MISSING;
            MODE_MISSING:
                if (!peak_low && !zc_lost)
                    nxt_mode = MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_ff <= MODE_NORMAL;
        else
            mode_ff <= nxt_mode;
    end

    assign fault_o = (mode_ff == MODE_MISSING);

    // register slave: one wait state, ack for every address
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign ev_set = {(mode_ff == MODE_MISSING) && (nxt_mode == MODE_NORMAL),
                     (mode_ff == MODE_NORMAL) && (nxt_mode == MODE_MISSING),
                     cf_fire_ff && (rev_ff != power_rate_i[16]),
                     cf_fire_ff};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= bus_req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            enable_ff <= `CTRL_RST;
            mask_ff <= `MASK_RST;
        end
        else if (bus_wr && wb_adr_i == `REG_CTRL)
            enable_ff <= wb_dat_i[0];
        else if (bus_wr && wb_adr_i == `REG_MASK)
            mask_ff <= wb_dat_i[3:0];
    end

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_ff <= 4'h0;
        else if (bus_wr && wb_adr_i == `REG_STATUS)
            status_ff <= (status_ff & ~wb_dat_i[3:0]) | ev_set;
        else
            status_ff <= status_ff | ev_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_ff <= 32'h0;
        else if (cf_fire_ff)
            count_ff <= count_ff + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_ff <= 32'h0;
        else if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `REG_CTRL: rdata_ff <= {31'h0, enable_ff};
                `REG_STATUS: rdata_ff <= {28'h0, status_ff};
                `REG_MASK: rdata_ff <= {28'h0, mask_ff};
                `REG_STATE: rdata_ff <= {25'h0, cal_scale_select_i, sel, 1'b0, creep_block, fault_o, rev_ff};
                `REG_COUNT: rdata_ff <= count_ff;
                default: rdata_ff <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status_ff & mask_ff);
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign irq_o = irq_ff;

    property p_rev_on_cf;
        @(posedge clk_i) disable iff (rst_i) $changed(rev_ff) |-> $past(cf_fire_ff);
    endproperty
    a_rev_on_cf: assert property (p_rev_on_cf) else $error("reverse flag moved without a pulse");

    property p_rev_sign;
        @(posedge clk_i) disable iff (rst_i) cf_fire_ff |=> rev_ff == $past(power_rate_i[16]);
    endproperty
    a_rev_sign: assert property (p_rev_sign) else $error("reverse flag wrong sign");

    property p_creep_hold;
        @(posedge clk_i) disable iff (rst_i) creep_block |=> acc_ff == $past(acc_ff) && !cf_fire_ff;
    endproperty
    a_creep_hold: assert property (p_creep_hold) else $error("creep load advanced pulses");

    property p_fast_no_creep;
        @(posedge clk_i) disable iff (rst_i) fast_mode |-> !creep_block && mult == 12'd2048;
    endproperty
    a_fast_no_creep: assert property (p_fast_no_creep) else $error("fast mode scaling wrong");

    property p_cross_fires;
        @(posedge clk_i) disable iff (rst_i)
            enable_ff && !creep_block && acc_ff + {23'h0, rate_sel} >= threshold |=> cf_fire_ff;
    endproperty
    a_cross_fires: assert property (p_cross_fires) else $error("threshold crossing gave no pulse");

    property p_cd_ratio;
        @(posedge clk_i) disable iff (rst_i) cd_fire_ff |-> $past(cf_fire_ff) && $past(cd_cnt_ff) == $past(mult) - 12'h1;
    endproperty
    a_cd_ratio: assert property (p_cd_ratio) else $error("counter drive ratio wrong");

    property p_fault_enter;
        @(posedge clk_i) disable iff (rst_i) peak_low |=> fault_o;
    endproperty
    a_fault_enter: assert property (p_fault_enter) else $error("low peak did not raise fault");

    property p_fault_leave;
        @(posedge clk_i) disable iff (rst_i) $fell(fault_o) |-> $past(!peak_low && !zc_lost);
    endproperty
    a_fault_leave: assert property (p_fault_leave) else $error("fault left too early");

    property p_fault_source;
        @(posedge clk_i) disable iff (rst_i) fault_o |-> rate_sel == {1'b0, amp_rate_i};
    endproperty
    a_fault_source: assert property (p_fault_source) else $error("fault mode not on current rate");

    property p_zc_enter;
        @(posedge clk_i) disable iff (rst_i) zc_lost |=> fault_o;
    endproperty
    a_zc_enter: assert property (p_zc_enter) else $error("lost zero crossings did not raise fault");

    property p_cal_from_fire;
        @(posedge clk_i) disable iff (rst_i) $rose(calibration_pulse_out_o) |-> $past(cf_fire_ff);
    endproperty
    a_cal_from_fire: assert property (p_cal_from_fire) else $error("calibration pulse without fire");

    property p_normal_source;
        @(posedge clk_i) disable iff (rst_i) !fault_o |-> rate_sel == power_mag;
    endproperty
    a_normal_source: assert property (p_normal_source) else $error("normal mode not on power rate");

    c_cf_pulse: cover property (@(posedge clk_i) disable iff (rst_i) cf_fire_ff);
    c_cd_pulse: cover property (@(posedge clk_i) disable iff (rst_i) cd_fire_ff);
    c_fault: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fault_o));
    c_reverse: cover property (@(posedge clk_i) disable iff (rst_i) $rose(reverse_power_flag_o));
    c_creep: cover property (@(posedge clk_i) disable iff (rst_i) creep_block && !fast_mode);
endmodule : energy_pulse_output_logic

// >>> sim/pulse_counter_model.sv
`timescale 1ns/1ps
module pulse_counter_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cal_i,
    input wire logic drv_i,
    output int n_cal,
    output int n_drv,
    output int iv,
    output int wd
);
    int t;
    int t_up;
    logic cal_q;
    logic drv_q;
    // polled like a counter port, so every edge is seen one clock late
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            t <= 0;
            t_up <= 0;
            cal_q <= 1'b0;
            drv_q <= 1'b0;
            n_cal <= 0;
            n_drv <= 0;
            iv <= 0;
            wd <= 0;
        end
        else
        begin
            t <= t + 1;
            cal_q <= cal_i;
            drv_q <= drv_i;
            if (cal_i && !cal_q)
            begin
                n_cal <= n_cal + 1;
                iv <= t - t_up;
                t_up <= t;
            end
            if (!cal_i && cal_q)
                wd <= t - t_up;
            if (drv_i && !drv_q)
                n_drv <= n_drv + 1;
        end
    end
endmodule : pulse_counter_model

// >>> sim/energy_pulse_output_logic_tb.sv
`timescale 1ns/1ps
module energy_pulse_output_logic_tb;
    import epo_pkg::*;
    localparam cycles_t PMAX = 32'd2000;
    localparam cycles_t ZCT = 32'd50;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_w = 1'b0;
    logic stb_w = 1'b0;
    logic we_w = 1'b0;
    logic [7:0] adr_w = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack_r;
    logic lo = 1'b1;
    logic hi = 1'b1;
    logic scl = 1'b0;
    logic signed [16:0] pwr = 17'sh0;
    logic [15:0] amp = 16'h0;
    logic [15:0] vpk = 16'hffff;
    logic zc = 1'b0;
    logic zc_on = 1'b1;
    logic cal, drv_a, drv_b, rev, fault, irq;
    int n_cal, n_drv, iv, wd;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int zc_n = 0;
    int r;
    int c0;
    logic [31:0] lfsr = 32'h153b23e0;
    logic [31:0] rd;

    energy_pulse_output_logic #(.PULSE_MAX_CYC(PMAX), .ZC_TIMEOUT_CYC(ZCT)) energy_pulse_output_logic_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_w), .wb_stb_i(stb_w), .wb_we_i(we_w),
        .wb_adr_i(adr_w), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack_r),
        .freq_select_lo_i(lo), .freq_select_hi_i(hi), .cal_scale_select_i(scl), .power_rate_i(pwr),
        .amp_rate_i(amp), .v_peak_i(vpk), .zero_cross_i(zc), .calibration_pulse_out_o(cal),
        .counter_drive_a_o(drv_a), .counter_drive_b_o(drv_b), .reverse_power_flag_o(rev),
        .fault_o(fault), .irq_o(irq));
    pulse_counter_model pulse_counter_model_i (.clk_i(clk_i), .rst_i(rst_i), .cal_i(cal),
        .drv_i(drv_a | drv_b), .n_cal(n_cal), .n_drv(n_drv), .iv(iv), .wd(wd));

    always #5 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // line voltage crossings every 20 cycles unless a scenario silences them
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        zc_n <= (zc_n == 19) ? 0 : zc_n + 1;
        zc <= zc_on && (zc_n == 0);
        if (cyc == 99000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // the accumulator keeps its remainder, so each interval is either floor or floor+1
    task automatic chk_time(input int got, input int exp);
        checks++;
        if (got < exp || got > exp + 1)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_time

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    function automatic longint thr(input logic s, input logic h, input logic l);
        longint b;
        longint m;
        b = h ? (l ? 13500 : 6860) : (l ? 3440 : 1720);
        m = s ? 64 : ((h && l) ? 2048 : 128);
        return 64'd6553500000000000 / (b * m);
    endfunction : thr

    // waits for ack as long as it takes; only the cycle ceiling ends a hang
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        cyc_w <= 1'b1;
        stb_w <= 1'b1;
        we_w <= we;
        adr_w <= a;
        dat_w <= d;
        @(posedge clk_i);
        while (ack_r !== 1'b1)
        begin
            @(posedge clk_i);
        end
        rd = dat_r;
        cyc_w <= 1'b0;
        stb_w <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_cal(input int n);
        int tgt;
        tgt = n_cal + n;
        while (n_cal < tgt || cal !== 1'b0)
            @(posedge clk_i);
        @(posedge clk_i);
    endtask : wait_cal

    task automatic run_rate(input int rt);
        int e;
        e = int'(thr(1'b0, 1'b1, 1'b1) / rt);
        wait_cal(3);
        chk_time(iv, e);
        chk_time(wd, (e / 2 < PMAX) ? e / 2 : PMAX);
        $display("rate %0d test done", rt);
    endtask : run_rate

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        chk_val(rd, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk_val(rd, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        chk_val(rd, 32'h0);
        pwr <= 17'sd2;
        for (int c = 0; c < 8; c++)
        begin
            {scl, hi, lo} <= 3'(c);
            repeat (3) @(posedge clk_i);
            wb(1'b0, 8'h0c, 32'h0);
            chk_val(rd & 32'h74, {25'h0, 3'(c), 1'b0, c != 3, 2'b0});
        end
        pwr <= 17'sd3;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 8'h0c, 32'h0);
        chk_val(rd[2], 1'b0);
        {scl, hi, lo} <= 3'b011;
        $display("creep test done");
        pwr <= 17'sd65535;
        run_rate(65535);
        pwr <= 17'sd32768;
        run_rate(32768);
        wb(1'b1, 8'h00, 32'h0);
        c0 = n_cal;
        // long enough that an enabled accumulator would have fired again
        repeat (8000) @(posedge clk_i);
        chk_val(n_cal, c0);
        wb(1'b1, 8'h00, 32'h1);
        $display("enable test done");
        lfsr = lfsr_step(lfsr);
        r = 30000 + int'(lfsr % 32'd35000);
        wait_cal(1);
        pwr <= -17'(r);
        repeat (50) @(posedge clk_i);
        chk_val(rev, 1'b0);
        run_rate(r);
        chk_val(rev, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk_val(rd[1], 1'b1);
        chk_val(irq, 1'b0);
        wb(1'b1, 8'h08, 32'h2);
        chk_val(irq, 1'b1);
        wb(1'b1, 8'h04, 32'h2);
        chk_val(irq, 1'b0);
        $display("reverse test done");
        pwr <= 17'sh0;
        amp <= 16'hffff;
        vpk <= 16'd5898;
        repeat (3) @(posedge clk_i);
        chk_val(fault, 1'b1);
        run_rate(65535);
        vpk <= 16'd5899;
        repeat (3) @(posedge clk_i);
        chk_val(fault, 1'b0);
        zc_on <= 1'b0;
        repeat (ZCT + 8) @(posedge clk_i);
        chk_val(fault, 1'b1);
        zc_on <= 1'b1;
        repeat (25) @(posedge clk_i);
        chk_val(fault, 1'b0);
        wb(1'b0, 8'h04, 32'h0);
        chk_val(rd[3:2], 2'b11);
        $display("fault test done");
        wb(1'b0, 8'h10, 32'h0);
        chk_val(rd, n_cal);
        chk_val(n_drv, 0);
        close_out();
    end
endmodule : energy_pulse_output_logic_tb
